//--- hw/fucc_pkg.sv
// Constants for the filtered up/down counter channel.
// Assumes the system clock also acts as the channel's counting time base.
package fucc_pkg;
    localparam int          CLK_PERIOD_NS = 10;
    // Register byte offsets
    localparam logic [7:0]  REG_CTRL      = 8'h00;
    localparam logic [7:0]  REG_COUNT     = 8'h04;
    localparam logic [7:0]  REG_S_COUNT   = 8'h08;
    localparam logic [7:0]  REG_S_TBASE   = 8'h0C;
    localparam logic [7:0]  REG_S_FRAC    = 8'h10;
    localparam logic [7:0]  REG_S_PERIOD  = 8'h14;
    // Control field positions
    localparam int          CTL_MODE_LO   = 0;
    localparam int          CTL_DOWN      = 2;
    localparam int          CTL_RST_START = 3;
    localparam int          CTL_ZERO_MODE = 4;
    localparam int          CTL_FLT0_LO   = 8;
    localparam int          CTL_FLT1_LO   = 12;
    localparam logic [15:0] CTRL_RESET    = 16'h0008;
    localparam logic [15:0] CTRL_MASK     = 16'h771F;
    // Counting modes
    localparam logic [1:0]  MODE_SINGLE   = 2'h0;
    localparam logic [1:0]  MODE_UPDOWN   = 2'h1;
    localparam logic [1:0]  MODE_FREQ     = 2'h2;
    // Filter gate times in ns, setting 0 is off
    localparam int          GATE_1_NS     = 100;
    localparam int          GATE_2_NS     = 200;
    localparam int          GATE_3_NS     = 500;
    localparam int          GATE_4_NS     = 1000;
    localparam int          GATE_5_NS     = 2000;
    localparam int          GATE_6_NS     = 4000;
    localparam int          GATE_7_NS     = 5000;
    localparam logic [9:0]  GATE_1_CYC    = 10'((GATE_1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [9:0]  GATE_2_CYC    = 10'((GATE_2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [9:0]  GATE_3_CYC    = 10'((GATE_3_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [9:0]  GATE_4_CYC    = 10'((GATE_4_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [9:0]  GATE_5_CYC    = 10'((GATE_5_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [9:0]  GATE_6_CYC    = 10'((GATE_6_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [9:0]  GATE_7_CYC    = 10'((GATE_7_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [3:0]  FRAC_BITS     = 4'h8;
    localparam logic [31:0] CNT_ONE       = 32'h0000_0001;
    typedef enum logic [1:0] {
        DIV_IDLE = 2'b01,
        DIV_RUN  = 2'b10
    } fucc_div_e;
endpackage : fucc_pkg

//--- hw/fucc_channel.sv
// One filtered counter channel: single-input, up/down and paired frequency counting.
// Assumes pins are asynchronous; sample and acquisition-start strobes are on i_clk_sys.
`timescale 1ns/1ns

// Summary of operation
// (RQ1) Up/down mode: up pin edge increments
// (RQ2) Up/down mode: down pin edge decrements
// (RQ3) Latch counter value on every sample
// (RQ4) Frequency uses fixed adjacent counter pair
// (RQ5) First counter counts source rising edges
// (RQ6) Second counter counts time base cycles
// (RQ7) Source edge captures time base count
// (RQ8) Sample reads both counts together
// (RQ9) Interpolate fractional count at sample
// (RQ10) Independent selectable filter per input
// (RQ11) Filter off passes input unchanged
// (RQ12) Filter samples on every time base edge
// (RQ13) New level passes after stable gate time
// (RQ14) Eight gate settings, off to 5 us
// (RQ15) Pass pulses at gate, block shorter
// (RQ16) Reset-on-start clears counters at start
// (RQ17) Without reset-on-start, counters keep running
// (RQ18) Default single input counts up
// (RQ19) Down direction without second input
// (RQ20) Repeat mode holds last period value
// (RQ21) Zero mode outputs zero without news
// (RQ22) 32-bit counters wrap modulo 2^32
module fucc_channel
    import fucc_pkg::*;
(
    input  wire logic        i_clk_sys,
    input  wire logic        i_reset,
    input  wire logic        i_primary_count_pin,
    input  wire logic        i_auxiliary_count_pin,
    input  wire logic        i_acq_start,
    input  wire logic        i_sample,
    input  wire logic [7:0]  i_addr,
    input  wire logic [31:0] i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic      [31:0] o_rdata,
    output logic      [31:0] o_sample_count,
    output logic      [31:0] o_sample_tbase,
    output logic      [31:0] o_sample_period,
    output logic      [7:0]  o_sample_frac,
    output logic             o_sample_valid
);

    default clocking @(posedge i_clk_sys);
    endclocking
    default disable iff (i_reset);

    function automatic logic [9:0] gate_cycles(input logic [2:0] sel);
        logic [9:0] g;
        g = 10'h001;
        unique case (sel)
            3'h1: g = GATE_1_CYC;
            3'h2: g = GATE_2_CYC;
            3'h3: g = GATE_3_CYC;
            3'h4: g = GATE_4_CYC;
            3'h5: g = GATE_5_CYC;
            3'h6: g = GATE_6_CYC;
            3'h7: g = GATE_7_CYC;
            3'h0: g = 10'h001;
        endcase
        return g;
    endfunction : gate_cycles

    logic [15:0] ctrl_q;
    logic [1:0]  sync1_q;
    logic [1:0]  sync2_q;
    logic [1:0]  flt_q;
    logic [9:0]  flt_cnt_q [2];
    logic [1:0]  fin_prev_q;
    logic [31:0] count_q;
    logic [31:0] tbase_q;
    logic [31:0] tb_cap_q;
    logic [31:0] tb_prev_q;
    logic        new_meas_q;
    logic [31:0] period_q;
    fucc_div_e   div_state_q;
    logic [31:0] rem_q;
    logic [31:0] div_q;
    logic [7:0]  quo_q;
    logic [3:0]  div_cnt_q;
    logic [31:0] rdata_q;
    logic [31:0] s_count_q;
    logic [31:0] s_tbase_q;
    logic [31:0] s_period_q;
    logic [7:0]  s_frac_q;
    logic        s_valid_q;

    wire logic [1:0]  mode       = ctrl_q[CTL_MODE_LO +: 2];
    wire logic        dir_down   = ctrl_q[CTL_DOWN];
    wire logic        rst_start  = ctrl_q[CTL_RST_START];
    wire logic        zero_mode  = ctrl_q[CTL_ZERO_MODE];
    wire logic [2:0]  flt_sel [2];
    assign flt_sel[0] = ctrl_q[CTL_FLT0_LO +: 3];
    assign flt_sel[1] = ctrl_q[CTL_FLT1_LO +: 3];

    // Filter output, bypassed when off
    wire logic [1:0]  fin;
    assign fin[0] = (flt_sel[0] == 3'h0) ? sync2_q[0] : flt_q[0]; // RQ11
    assign fin[1] = (flt_sel[1] == 3'h0) ? sync2_q[1] : flt_q[1]; // RQ11
    wire logic [1:0]  rise       = fin & ~fin_prev_q;
    wire logic        is_updown  = (mode == MODE_UPDOWN);
    wire logic        is_freq    = (mode == MODE_FREQ);
    wire logic        clr        = i_acq_start & rst_start; // RQ16 RQ17
    wire logic        inc        = is_updown ? (rise[0] & ~rise[1])   // RQ1
                                   : (rise[0] & (~dir_down | is_freq)); // RQ5 RQ18
    wire logic        dec        = is_updown ? (rise[1] & ~rise[0])   // RQ2
                                   : (rise[0] & dir_down & ~is_freq); // RQ19
    wire logic        src_edge   = is_freq & rise[0];
    wire logic [31:0] count_d    = clr ? 32'h0000_0000
                                   : inc ? count_q + CNT_ONE          // RQ22
                                   : dec ? count_q - CNT_ONE
                                   : count_q;
    wire logic [31:0] elapsed    = tbase_q - tb_cap_q;
    wire logic [31:0] meas_per   = tb_cap_q - tb_prev_q;
    wire logic        div_go     = i_sample & is_freq & (div_state_q == DIV_IDLE);
    wire logic [32:0] rem_shift  = {rem_q, 1'b0};
    wire logic        rem_ge     = (rem_shift >= {1'b0, div_q});
    wire logic [31:0] period_out = (zero_mode & ~new_meas_q) ? 32'h0000_0000 // RQ21
                                   : period_q;                               // RQ20

    // Register read decode
    wire logic [31:0] rd_mux     = (i_addr == REG_CTRL)     ? {16'h0000, ctrl_q}
                                 : (i_addr == REG_COUNT)    ? count_q
                                 : (i_addr == REG_S_COUNT)  ? s_count_q
                                 : (i_addr == REG_S_TBASE)  ? s_tbase_q
                                 : (i_addr == REG_S_FRAC)   ? {24'h000000, s_frac_q}
                                 : (i_addr == REG_S_PERIOD) ? s_period_q
                                 : 32'h0000_0000;

    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            ctrl_q <= CTRL_RESET;
        end else if (i_wr && i_addr == REG_CTRL) begin
            ctrl_q <= i_wdata[15:0] & CTRL_MASK; // RQ14
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            rdata_q <= 32'h0000_0000;
        end else begin
            rdata_q <= i_rd ? rd_mux : 32'h0000_0000;
        end
    end

    // Pin synchronisers, one per input
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            sync1_q <= 2'h0;
            sync2_q <= 2'h0;
        end else begin
            sync1_q <= {i_auxiliary_count_pin, i_primary_count_pin};
            sync2_q <= sync1_q;
        end
    end

    // Glitch filters sampled every time base edge
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            flt_q <= 2'h0;
            flt_cnt_q[0] <= 10'h000;
            flt_cnt_q[1] <= 10'h000;
        end else begin
            for (int i = 0; i < 2; i++) begin // RQ10 RQ12
                if (sync2_q[i] == flt_q[i]) begin
                    flt_cnt_q[i] <= 10'h000;
                end else if (flt_cnt_q[i] + 10'h001 >= gate_cycles(flt_sel[i])) begin
                    flt_q[i] <= sync2_q[i]; // RQ13 RQ15
                    flt_cnt_q[i] <= 10'h000;
                end else begin
                    flt_cnt_q[i] <= flt_cnt_q[i] + 10'h001;
                end
            end
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            fin_prev_q <= 2'h0;
            count_q <= 32'h0000_0000;
        end else begin
            fin_prev_q <= fin;
            count_q <= count_d;
        end
    end

    // Time base half of the pair and edge capture
    always_ff @(posedge i_clk_sys) begin
        if (i_reset || clr) begin
            tbase_q <= 32'h0000_0000;
            tb_cap_q <= 32'h0000_0000;
            tb_prev_q <= 32'h0000_0000;
        end else begin
            tbase_q <= tbase_q + CNT_ONE; // RQ4 RQ6
            if (src_edge) begin
                tb_cap_q <= tbase_q; // RQ7
                tb_prev_q <= tb_cap_q;
            end
        end
    end

    // New measurement flag; an edge wins over the sample clear
    always_ff @(posedge i_clk_sys) begin
        if (i_reset || clr) begin
            new_meas_q <= 1'b0;
            period_q <= 32'h0000_0000;
        end else begin
            if (src_edge) begin
                new_meas_q <= 1'b1;
                period_q <= tbase_q - tb_cap_q;
            end else if (i_sample) begin
                new_meas_q <= 1'b0;
            end
        end
    end

    // Sample latch
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            s_count_q <= 32'h0000_0000;
            s_tbase_q <= 32'h0000_0000;
            s_period_q <= 32'h0000_0000;
        end else if (i_sample) begin
            s_count_q <= count_q; // RQ3 RQ8
            s_tbase_q <= tb_cap_q; // RQ8
            s_period_q <= period_out;
        end
    end

    // Fraction of a source period elapsed at the sample instant
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            div_state_q <= DIV_IDLE;
            rem_q <= 32'h0000_0000;
            div_q <= 32'h0000_0000;
            quo_q <= 8'h00;
            div_cnt_q <= 4'h0;
            s_frac_q <= 8'h00;
            s_valid_q <= 1'b0;
        end else begin
            s_valid_q <= 1'b0;
            unique case (div_state_q)
                DIV_IDLE: begin
                    if (i_sample && !is_freq) begin
                        s_frac_q <= 8'h00;
                        s_valid_q <= 1'b1;
                    end else if (div_go) begin
                        if (meas_per == 32'h0000_0000 || elapsed >= meas_per) begin
                            s_frac_q <= 8'hFF;
                            s_valid_q <= 1'b1;
                        end else begin
                            rem_q <= elapsed; // RQ9
                            div_q <= meas_per;
                            quo_q <= 8'h00;
                            div_cnt_q <= 4'h0;
                            div_state_q <= DIV_RUN;
                        end
                    end
                end
                DIV_RUN: begin
                    rem_q <= rem_ge ? 32'(rem_shift - {1'b0, div_q}) : rem_shift[31:0];
                    quo_q <= {quo_q[6:0], rem_ge};
                    div_cnt_q <= div_cnt_q + 4'h1;
                    if (div_cnt_q == FRAC_BITS - 4'h1) begin
                        s_frac_q <= {quo_q[6:0], rem_ge}; // RQ9
                        s_valid_q <= 1'b1;
                        div_state_q <= DIV_IDLE;
                    end
                end
            endcase
        end
    end

    assign o_rdata = rdata_q;
    assign o_sample_count = s_count_q;
    assign o_sample_tbase = s_tbase_q;
    assign o_sample_period = s_period_q;
    assign o_sample_frac = s_frac_q;
    assign o_sample_valid = s_valid_q;

    // Checks
    a_up_count: assert property (@(posedge i_clk_sys) disable iff (i_reset) // RQ1
        is_updown && rise[0] && !rise[1] && !clr |=> count_q == $past(count_q) + CNT_ONE)
        else $error("up edge did not increment");
    a_down_count: assert property (@(posedge i_clk_sys) disable iff (i_reset) // RQ2
        is_updown && rise[1] && !rise[0] && !clr |=> count_q == $past(count_q) - CNT_ONE)
        else $error("down edge did not decrement");
    a_dir_down: assert property (@(posedge i_clk_sys) disable iff (i_reset) // RQ19
        mode == MODE_SINGLE && dir_down && rise[0] && !clr
        |=> count_q == $past(count_q) - CNT_ONE)
        else $error("down direction did not decrement");
    a_sample_latch: assert property (@(posedge i_clk_sys) disable iff (i_reset) // RQ3
        i_sample |=> o_sample_count == $past(count_q) && o_sample_tbase == $past(tb_cap_q))
        else $error("sample did not latch counts");
    a_tb_capture: assert property (@(posedge i_clk_sys) disable iff (i_reset) // RQ7
        src_edge && !clr |=> tb_cap_q == $past(tbase_q) && tb_prev_q == $past(tb_cap_q))
        else $error("time base not captured on edge");
    a_tb_runs: assert property (@(posedge i_clk_sys) disable iff (i_reset) // RQ6
        !clr ##1 !clr |-> tbase_q == $past(tbase_q) + CNT_ONE)
        else $error("time base did not advance");
    a_filter_off: assert property (@(posedge i_clk_sys) disable iff (i_reset) // RQ11
        flt_sel[0] == 3'h0 |-> fin[0] == sync2_q[0])
        else $error("filter off not transparent");
    a_filter_hold: assert property (@(posedge i_clk_sys) disable iff (i_reset) // RQ13
        flt_sel[0] == 3'h1 && $stable(flt_sel[0]) && $changed(flt_q[0])
        |-> $past(flt_cnt_q[0]) == GATE_1_CYC - 10'h001)
        else $error("filter passed before gate time");
    a_start_clear: assert property (@(posedge i_clk_sys) disable iff (i_reset) // RQ16
        clr |=> count_q == 32'h0000_0000 && tbase_q == 32'h0000_0000)
        else $error("start did not clear counters");
    a_zero_mode: assert property (@(posedge i_clk_sys) disable iff (i_reset) // RQ21
        i_sample && zero_mode && !new_meas_q |=> o_sample_period == 32'h0000_0000)
        else $error("zero mode output not zero");
    a_frac_done: assert property (@(posedge i_clk_sys) disable iff (i_reset) // RQ9
        div_state_q == DIV_IDLE ##1 div_state_q == DIV_RUN |-> ##8 o_sample_valid)
        else $error("fraction not ready in eight cycles");

    // Counting, capture, filter and output checks
    a_freq_up: assert property ( // RQ5
        is_freq && rise[0] && !clr |=> count_q == $past(count_q) + CNT_ONE)
        else $error("source edge did not count up");
    a_single_up: assert property ( // RQ18
        mode == MODE_SINGLE && !dir_down && rise[0] && !clr
        |=> count_q == $past(count_q) + CNT_ONE)
        else $error("default direction did not count up");
    a_count_keep: assert property ( // RQ17
        !clr && !inc && !dec |=> $stable(count_q))
        else $error("counter moved without an edge");
    a_period_hold: assert property ( // RQ20
        !src_edge && !clr |=> $stable(period_q))
        else $error("period changed without an edge");
    a_repeat_out: assert property ( // RQ20
        i_sample && !zero_mode |=> o_sample_period == $past(period_q))
        else $error("repeat mode lost last period");
    a_zero_new: assert property ( // RQ21
        i_sample && zero_mode && new_meas_q |=> o_sample_period == $past(period_q))
        else $error("zero mode hid a new period");
    a_new_clear: assert property ( // RQ21
        i_sample && !src_edge |=> !new_meas_q)
        else $error("sample left news flag set");
    a_edge_news: assert property ( // RQ7
        src_edge && !clr |=> new_meas_q && period_q == $past(elapsed))
        else $error("edge did not store period");
    a_tb_hold: assert property ( // RQ7
        !src_edge && !clr |=> $stable(tb_cap_q))
        else $error("capture moved without an edge");
    a_filter_quiet: assert property ( // RQ13
        sync2_q[1] == flt_q[1] |=> $stable(flt_q[1]) && flt_cnt_q[1] == 10'h000)
        else $error("aux filter moved while quiet");
    a_aux_off: assert property ( // RQ11
        flt_sel[1] == 3'h0 |-> fin[1] == sync2_q[1])
        else $error("aux filter off not transparent");
    a_gate_range: assert property ( // RQ14
        flt_cnt_q[0] < GATE_7_CYC && flt_cnt_q[1] < GATE_7_CYC)
        else $error("filter count beyond gate");
    a_clear_capture: assert property ( // RQ16
        clr |=> tb_cap_q == 32'h0000_0000 && period_q == 32'h0000_0000 && !new_meas_q)
        else $error("start did not clear captures");
    a_frac_sat: assert property ( // RQ9
        div_go && (meas_per == 32'h0000_0000 || elapsed >= meas_per)
        |=> o_sample_frac == 8'hFF && o_sample_valid)
        else $error("late sample not saturated");
    a_single_frac: assert property ( // RQ3
        i_sample && !is_freq && div_state_q == DIV_IDLE
        |=> o_sample_valid && o_sample_frac == 8'h00)
        else $error("sample gave no zero fraction");

    c_updown: cover property (@(posedge i_clk_sys) is_updown && inc ##1 is_updown && dec);
    c_freq_sample: cover property (@(posedge i_clk_sys) src_edge ##[1:50] div_go);
    c_filter_block: cover property (@(posedge i_clk_sys)
        flt_sel[0] != 3'h0 && sync2_q[0] != flt_q[0] ##1 sync2_q[0] == flt_q[0]);
    c_repeat: cover property (@(posedge i_clk_sys) i_sample && !zero_mode && !new_meas_q);
    c_frac_divide: cover property (@(posedge i_clk_sys) div_state_q == DIV_RUN ##8 o_sample_valid);

endmodule : fucc_channel

//--- testbench/fucc_pulse_src.sv
// Pulse source model standing at the channel's two count pins.
// Assumes the bench calls its task from one process at a time, on i_clk_sys.
`timescale 1ns/1ns
module fucc_pulse_src (
    input  wire logic i_clk_sys,
    output logic      o_primary,
    output logic      o_auxiliary
);
    initial begin
        o_primary   = 1'b0;
        o_auxiliary = 1'b0;
    end

    // One pulse, widths in clock cycles; rise to rise spacing is hi + lo
    task automatic pulse(input logic aux, input int hi, input int lo);
        @(posedge i_clk_sys);
        if (aux) begin
            o_auxiliary <= 1'b1;
        end else begin
            o_primary <= 1'b1;
        end
        repeat (hi) @(posedge i_clk_sys);
        o_auxiliary <= 1'b0;
        o_primary   <= 1'b0;
        repeat (lo - 1) @(posedge i_clk_sys);
    endtask : pulse
endmodule : fucc_pulse_src

//--- testbench/filtered_updown_counter_channel_tb.sv
// Self-checking bench for one filtered counter channel.
// Assumes a 100 MHz clock that also serves as the counting time base.
`timescale 1ns/1ns
module filtered_updown_counter_channel_tb;
    import fucc_pkg::*;
    logic        i_clk_sys, i_reset, i_acq_start, i_sample, i_wr, i_rd;
    logic [7:0]  i_addr;
    logic [31:0] i_wdata, o_rdata, o_sample_count, o_sample_tbase, o_sample_period, rd_val;
    logic [7:0]  o_sample_frac;
    logic        o_sample_valid, pin_p, pin_a;
    int          errors, cmp_count, n, p, g;

    fucc_pulse_src u_src (.i_clk_sys(i_clk_sys), .o_primary(pin_p), .o_auxiliary(pin_a));
    fucc_channel u_dut (
        .i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_primary_count_pin(pin_p),
        .i_auxiliary_count_pin(pin_a), .i_acq_start(i_acq_start), .i_sample(i_sample),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .o_sample_count(o_sample_count), .o_sample_tbase(o_sample_tbase),
        .o_sample_period(o_sample_period), .o_sample_frac(o_sample_frac),
        .o_sample_valid(o_sample_valid));

    initial begin
        i_clk_sys = 1'b0;
        forever #5 i_clk_sys = ~i_clk_sys;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : end_of_test

    function automatic logic [31:0] ctrl(input logic [1:0] mode, input logic dn,
                                         input logic rst, input logic zero,
                                         input logic [2:0] f0, input logic [2:0] f1);
        ctrl = 32'h0000_0000;
        ctrl[CTL_MODE_LO +: 2] = mode;
        ctrl[CTL_DOWN]         = dn;
        ctrl[CTL_RST_START]    = rst;
        ctrl[CTL_ZERO_MODE]    = zero;
        ctrl[CTL_FLT0_LO +: 3] = f0;
        ctrl[CTL_FLT1_LO +: 3] = f1;
    endfunction : ctrl

    function automatic int gate_cyc(input int sel);
        case (sel)
            1: gate_cyc = int'(GATE_1_CYC);
            2: gate_cyc = int'(GATE_2_CYC);
            default: gate_cyc = int'(GATE_3_CYC);
        endcase
    endfunction : gate_cyc

    // Fraction of a period elapsed, in 1/256 steps
    function automatic logic [31:0] frac_exp(input int e, input int per);
        frac_exp = 32'((e * 256) / per);
    endfunction : frac_exp

    // Bounded wait for the fraction to be ready
    task automatic wait_valid();
        g = 0;
        while (o_sample_valid !== 1'b1 && g < 20) begin
            @(posedge i_clk_sys);
            #1;
            g++;
        end
        check({31'h0, o_sample_valid}, 32'h1);
        if (o_sample_valid !== 1'b1) begin
            end_of_test();
        end
    endtask : wait_valid

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk_sys);
        i_addr  <= a;
        i_wdata <= d;
        i_wr    <= 1'b1;
        @(posedge i_clk_sys);
        i_wr    <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a);
        @(posedge i_clk_sys);
        i_addr <= a;
        i_rd   <= 1'b1;
        @(posedge i_clk_sys);
        i_rd   <= 1'b0;
        #1;
        rd_val = o_rdata;
    endtask : rd

    task automatic strobe(input bit smp);
        @(posedge i_clk_sys);
        if (smp) begin
            i_sample <= 1'b1;
        end else begin
            i_acq_start <= 1'b1;
        end
        @(posedge i_clk_sys);
        i_sample    <= 1'b0;
        i_acq_start <= 1'b0;
        #1;
    endtask : strobe

    // Start clean in a mode: write the control word, then strobe acquisition start
    task automatic start(input logic [31:0] c);
        wr(REG_CTRL, c);
        strobe(0);
    endtask : start

    task automatic pulses(input logic aux, input int k, input int hi, input int lo);
        repeat (k) u_src.pulse(aux, hi, lo);
        repeat (8) @(posedge i_clk_sys);
    endtask : pulses

    initial begin
        #900_000;
        errors++;
        end_of_test();
    end

    initial begin
        {i_reset, i_acq_start, i_sample, i_wr, i_rd} = 5'b10000;
        i_addr  = 8'h00;
        i_wdata = 32'h0000_0000;
        errors = 0;
        cmp_count = 0;
        void'($urandom(32'hEE83));
        repeat (4) @(posedge i_clk_sys);
        i_reset <= 1'b0;
        rd(REG_CTRL);
        check(rd_val, {16'h0000, CTRL_RESET});
        rd(8'h40);
        check(rd_val, 32'h0000_0000);
        $display("Reset values done");
        // Default single-input up count, then sample latch
        n = $urandom_range(20, 1);
        start(ctrl(MODE_SINGLE, 1'b0, 1'b1, 1'b0, 3'h0, 3'h0));
        pulses(1'b0, n, 1, 1);
        rd(REG_COUNT);
        check(rd_val, 32'(n));
        strobe(1);
        check(o_sample_count, 32'(n));
        check({31'h0, o_sample_valid}, 32'h1);
        check({24'h0, o_sample_frac}, 32'h0000_0000);
        // Without reset-on-start the count survives a new acquisition
        wr(REG_CTRL, ctrl(MODE_SINGLE, 1'b0, 1'b0, 1'b0, 3'h0, 3'h0));
        strobe(0);
        pulses(1'b0, 2, 2, 3);
        rd(REG_COUNT);
        check(rd_val, 32'(n + 2));
        wr(REG_CTRL, ctrl(MODE_SINGLE, 1'b1, 1'b1, 1'b0, 3'h0, 3'h0));
        strobe(0);
        rd(REG_COUNT);
        check(rd_val, 32'h0000_0000);
        pulses(1'b0, 1, 2, 2);
        rd(REG_COUNT);
        check(rd_val, 32'hFFFF_FFFF);
        $display("Single-input counting done");
        // Up/down mode with random up and down edge counts
        n = $urandom_range(12, 1);
        p = $urandom_range(12, 1);
        start(ctrl(MODE_UPDOWN, 1'b0, 1'b1, 1'b0, 3'h0, 3'h0));
        pulses(1'b0, n, 1, 2);
        pulses(1'b1, p, 2, 1);
        rd(REG_COUNT);
        check(rd_val, 32'(n - p));
        $display("Up/down counting done");
        // Filters per input: long pulse passes, pulse short of gate is blocked
        for (int s = 1; s <= 3; s++) begin
            g = gate_cyc(s);
            start(ctrl(MODE_UPDOWN, 1'b0, 1'b1, 1'b0, 3'(s), 3'(4 - s)));
            pulses(1'b0, 1, g + 1, g + 3);
            pulses(1'b0, 1, g - 3, g + 3);
            repeat (g) @(posedge i_clk_sys);
            rd(REG_COUNT);
            check(rd_val, 32'h0000_0001);
            g = gate_cyc(4 - s);
            pulses(1'b1, 1, g - 3, g + 3);
            pulses(1'b1, 1, g + 1, g + 3);
            repeat (g) @(posedge i_clk_sys);
            rd(REG_COUNT);
            check(rd_val, 32'h0000_0000);
        end
        $display("Filters done");
        // Frequency pair in repeat and zero modes
        for (int z = 0; z <= 1; z++) begin
            n = $urandom_range(6, 3);
            p = $urandom_range(40, 12);
            start(ctrl(MODE_FREQ, 1'b0, 1'b1, 1'(z), 3'h0, 3'h0));
            pulses(1'b0, n, 3, p - 3);
            for (int k = 0; k < 2; k++) begin
                strobe(1);
                check(o_sample_count, 32'(n));
                check(o_sample_period, (k == 1 && z == 1) ? 32'h0 : 32'(p));
                wait_valid();
                check({24'h0, o_sample_frac}, 32'h0000_00FF);
                rd(REG_S_TBASE);
                check(rd_val, o_sample_tbase);
            end
            // A sample inside a period runs the divider
            repeat (2) u_src.pulse(1'b0, 3, p - 3);
            strobe(1);
            check(o_sample_count, 32'(n + 2));
            check(o_sample_period, 32'(p));
            wait_valid();
            check({24'h0, o_sample_frac}, frac_exp(p - 2, p));
        end
        $display("Frequency measurement done");
        end_of_test();
    end
endmodule : filtered_updown_counter_channel_tb
